/* hdl/clnp_num_parse.sv */
`timescale 1ns/1ps
`default_nettype none
module clnp_num_parse
	import clnp_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// control
	input  wire logic        start,
	input  wire clnp_fmt_t   fmt,
	// character stream
	input  wire logic        in_valid,
	input  wire logic [7:0]  in_char,
	// result
	output logic [15:0]      value,
	output logic             done
);
	clnp_fmt_t   fmt_q;
	clnp_radix_t cur_radix;
	logic        active;
	logic        minus_pend;
	logic        pfx_seen;
	logic        neg;
	logic        in_num;
	logic [4:0]  cnt;
	logic [16:0] acc;

	// ****************************************
	// character decode
	// ****************************************
	wire clnp_radix_t scan_radix = pfx_seen ? cur_radix :
		(fmt_q.radix == RADIX_ANY) ? RADIX_TEN : fmt_q.radix;
	wire clnp_radix_t dig_radix = in_num ? cur_radix : scan_radix;
	wire logic [7:0]  lc        = in_char | 8'h20;
	wire logic        is_num    = (in_char >= 8'h30) && (in_char <= 8'h39);
	wire logic        is_hexl   = (lc >= 8'h61) && (lc <= 8'h66);
	wire logic [3:0]  dval      = is_num ? in_char[3:0] : 4'(in_char[3:0] + 4'h9);
	wire logic        dig_ok    = (dig_radix == RADIX_SIXTEEN) ? (is_num || is_hexl) :
		(dig_radix == RADIX_TWO) ? (in_char == 8'h30 || in_char == 8'h31) : is_num;
	wire logic [4:0]  base_lim  = (dig_radix == RADIX_SIXTEEN) ? HEX_MAX :
		(dig_radix == RADIX_TWO) ? BIN_MAX : DEC_MAX;
	wire logic [4:0]  lim       = (fmt_q.max_digits == 5'h00 || fmt_q.max_digits > base_lim) ?
		base_lim : fmt_q.max_digits;
	wire logic [16:0] mul       = (dig_radix == RADIX_SIXTEEN) ? {acc[12:0], 4'h0} :
		(dig_radix == RADIX_TWO) ? {acc[15:0], 1'b0} :
		17'({acc[13:0], 3'b000} + {acc[15:0], 1'b0});
	wire logic [16:0] acc_new   = 17'((in_num ? mul : 17'h00000) + {13'h0000, dval});
	wire logic [4:0]  new_cnt   = in_num ? 5'(cnt + 5'h01) : 5'h01;

	// ****************************************
	// scan decisions
	// ****************************************
	wire logic pfx_hex   = (fmt_q.radix == RADIX_ANY) || (fmt_q.radix == RADIX_SIXTEEN && fmt_q.prefixed);
	wire logic pfx_bin   = (fmt_q.radix == RADIX_ANY) || (fmt_q.radix == RADIX_TWO && fmt_q.prefixed);
	wire logic pfx_hit   = !in_num && !pfx_seen &&
		((in_char == CH_DOLLAR && pfx_hex) || (in_char == CH_PERCENT && pfx_bin));
	wire logic minus_hit = !in_num && fmt_q.signed_f && (in_char == CH_MINUS);
	wire logic start_ok  = !in_num && dig_ok && (!fmt_q.prefixed || pfx_seen);
	wire logic take      = active && in_valid;
	wire logic fin_digit = (in_num || start_ok) && dig_ok && (new_cnt == lim);
	wire logic fin_stop  = in_num && !dig_ok;
	wire logic [16:0] fin_mag = fin_stop ? acc : acc_new;
	wire logic fin_neg   = (in_num || pfx_seen) ? neg : minus_pend;
	wire logic sat_on    = fmt_q.signed_f && (fmt_q.radix == RADIX_ANY);
	wire logic [15:0] fin_val = (sat_on && !fin_neg && fin_mag > 17'h07fff) ? 16'h7fff :
		(sat_on && fin_neg && fin_mag > 17'h08000) ? 16'h8000 :
		fin_neg ? 16'(17'h00000 - fin_mag) : fin_mag[15:0];

	always_ff @(posedge sys_clk) begin
		if (reset || start) begin
			fmt_q      <= reset ? '0 : fmt;
			active     <= !reset;
			cur_radix  <= RADIX_TEN;
			{minus_pend, pfx_seen, neg, in_num, done} <= 5'h00;
			cnt        <= 5'h00;
			acc        <= 17'h00000;
			value      <= 16'h0000;
		end else if (take) begin
			if (fin_digit || fin_stop) begin
				active <= 1'b0;
				done   <= 1'b1;
				in_num <= 1'b0;
				// a one-digit field may end on its first numeral
				{minus_pend, pfx_seen} <= 2'b00;
				value  <= fin_val;
			end else if (in_num) begin
				acc <= acc_new;
				cnt <= new_cnt;
			end else if (start_ok) begin
				in_num     <= 1'b1;
				cur_radix  <= scan_radix;
				neg        <= fin_neg;
				acc        <= acc_new;
				cnt        <= 5'h01;
				minus_pend <= 1'b0;
				pfx_seen   <= 1'b0;
			end else if (minus_hit) begin
				minus_pend <= 1'b1;
				pfx_seen   <= 1'b0;
			end else if (pfx_hit) begin
				pfx_seen   <= 1'b1;
				neg        <= minus_pend;
				minus_pend <= 1'b0;
				cur_radix  <= (in_char == CH_DOLLAR) ? RADIX_SIXTEEN : RADIX_TWO;
			end else begin
				// any other character cancels a pending sign or prefix
				minus_pend <= 1'b0;
				pfx_seen   <= 1'b0;
				neg        <= 1'b0;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	limit_count_a: assert property (
		@(posedge sys_clk) disable iff (reset) in_num |-> (cnt < lim && cnt != 5'h00))
		else $error("digit count passed its limit");
	minus_drop_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		take && !start && !in_num && !minus_hit && !pfx_hit |=> !minus_pend)
		else $error("minus sign kept across a non-numeral");
	prefix_gate_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		active && !start && fmt_q.prefixed && !pfx_seen && !in_num |=> !in_num)
		else $error("number started without its prefix");
	hex_lower_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		dig_radix == RADIX_SIXTEEN && in_char >= 8'h61 && in_char <= 8'h66 |-> dig_ok)
		else $error("lower case hex digit refused");
endmodule // clnp_num_parse
`default_nettype wire

/* hdl/clnp_pkg.sv */
`default_nettype none
package clnp_pkg;
	// ****************************************
	// clock, nibble and instruction execution timing
	// ****************************************
	localparam int CLK_HZ    = 20_000_000;
	localparam int CLK_NS    = 1_000_000_000 / CLK_HZ;
	localparam int SETUP_NS  = 100;
	localparam int EHI_NS    = 500;
	localparam int HOLD_NS   = 100;
	localparam int EXEC_NS   = 40_000;
	localparam int LONG_NS   = 1_640_000;
	localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int EHI_CYC   = (EHI_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC  = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam int EXEC_CYC  = (EXEC_NS + CLK_NS - 1) / CLK_NS;
	localparam int LONG_CYC  = (LONG_NS + CLK_NS - 1) / CLK_NS;
	// ****************************************
	// pin layout inside a group of eight
	// ****************************************
	localparam logic [3:0] PIN_RW_OFS  = 4'h2;
	localparam logic [3:0] PIN_RS_OFS  = 4'h3;
	localparam logic [3:0] PIN_NIB_OFS = 4'h4;
	localparam logic [3:0] PIN_HI_GRP  = 4'h8;
	// ****************************************
	// display instructions, characters and digit limits
	// ****************************************
	localparam logic [7:0] INSTR_CLEAR      = 8'h01;
	localparam logic [7:0] INSTR_HOME       = 8'h02;
	localparam logic [7:0] INSTR_TEXT_ADDR  = 8'h80;
	localparam logic [7:0] INSTR_GLYPH_ADDR = 8'h40;
	localparam logic [7:0] CH_MINUS         = 8'h2d;
	localparam logic [7:0] CH_DOLLAR        = 8'h24;
	localparam logic [7:0] CH_PERCENT       = 8'h25;
	localparam logic [4:0] DEC_MAX          = 5'h05;
	localparam logic [4:0] HEX_MAX          = 5'h04;
	localparam logic [4:0] BIN_MAX          = 5'h10;
	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {OP_INSTR, OP_WRITE, OP_READ} clnp_op_t;
	typedef enum logic [1:0] {RADIX_TEN, RADIX_SIXTEEN, RADIX_TWO, RADIX_ANY} clnp_radix_t;
	// e.g. signed_prefixed_base_sixteen = sixteen, signed, prefixed
	typedef struct packed {
		clnp_radix_t radix;
		logic        signed_f;
		logic        prefixed;
		logic [4:0]  max_digits;
	} clnp_fmt_t;
	typedef struct packed {
		logic       e;
		logic       rw;
		logic       rs;
		logic [3:0] nib;
	} clnp_lines_t;
endpackage
`default_nettype wire

/* hdl/clnp_port.sv */
`timescale 1ns/1ps
`default_nettype none
module clnp_port
	import clnp_pkg::*;
#(
	parameter int LONG_WAIT_CYC = LONG_CYC,
	parameter int EXEC_WAIT_CYC = EXEC_CYC
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// operation request
	input  wire logic        op_start,
	input  wire clnp_op_t    op_kind,
	input  wire logic [1:0]  base_sel,
	input  wire logic [7:0]  instr_byte,
	input  wire logic [7:0]  read_len,
	output logic             busy,
	// write data stream
	input  wire logic        wr_valid,
	input  wire logic [7:0]  wr_data,
	input  wire logic        wr_last,
	output logic             wr_ready,
	// read data and conversion
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	input  wire clnp_fmt_t   fmt,
	output logic [15:0]      conv_value,
	output logic             conv_done,
	// general i/o pins
	input  wire logic [15:0] pin_in,
	output logic [15:0]      pin_out,
	output logic [15:0]      pin_oe
);
	if (EXEC_WAIT_CYC < 1 || LONG_WAIT_CYC < EXEC_WAIT_CYC || LONG_WAIT_CYC > 65535) begin : g_chk
		$error("wait counts out of range");
	end

	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_SETUP, S_EHI, S_HOLD, S_GAP} clnp_state_t;

	clnp_state_t state, next_state;
	clnp_op_t    op_q, next_op;
	clnp_lines_t lines_q, next_lines;
	logic [15:0] cnt, next_cnt;
	logic [1:0]  base_q, next_base;
	logic [7:0]  byte_q, next_byte;
	logic [7:0]  left, next_left;
	logic [3:0]  rd_hi, next_rd_hi;
	logic [7:0]  next_rd_data;
	logic        first, next_first;
	logic        low, next_low;
	logic        last_q, next_last;
	logic        ctl_oe, next_ctl_oe;
	logic        nib_oe, next_nib_oe;
	logic        next_wr_ready;
	logic        next_rd_valid;

	// ****************************************
	// pin placement
	// ****************************************
	wire logic [3:0]  grp      = base_q[1] ? PIN_HI_GRP : 4'h0;
	wire logic [3:0]  e_pos    = grp | {3'b000, base_q[0]};
	wire logic [3:0]  rw_pos   = grp | PIN_RW_OFS;
	wire logic [3:0]  rs_pos   = grp | PIN_RS_OFS;
	wire logic [3:0]  nib_pos  = grp | PIN_NIB_OFS;
	wire logic [15:0] ctl_mask = (16'h0001 << e_pos) | (16'h0001 << rw_pos) | (16'h0001 << rs_pos);
	wire logic [15:0] next_pin_out = (16'(lines_q.e) << e_pos) | (16'(lines_q.rw) << rw_pos) |
		(16'(lines_q.rs) << rs_pos) | (16'(lines_q.nib) << nib_pos);
	wire logic [15:0] next_pin_oe = (ctl_oe ? ctl_mask : 16'h0000) |
		(nib_oe ? (16'h000f << nib_pos) : 16'h0000);
	wire logic [3:0]  rd_nib   = 4'(pin_in >> nib_pos);
	wire logic        cnt_zero = (cnt == 16'h0000);
	// clear and home take far longer to execute than other instructions
	wire logic        slow_instr = first && (byte_q == INSTR_CLEAR || byte_q == INSTR_HOME);
	wire logic [15:0] gap_load = slow_instr ? 16'(LONG_WAIT_CYC - 1) : 16'(EXEC_WAIT_CYC - 1);
	wire logic        conv_start = op_start && (state == S_IDLE) && (op_kind == OP_READ);

	// ****************************************
	// transfer sequencer
	// ****************************************
	always_comb begin
		next_state    = state;
		next_op       = op_q;
		next_lines    = lines_q;
		next_cnt      = cnt_zero ? cnt : 16'(cnt - 16'h0001);
		next_base     = base_q;
		next_byte     = byte_q;
		next_left     = left;
		next_rd_hi    = rd_hi;
		next_rd_data  = rd_data;
		next_first    = first;
		next_low      = low;
		next_last     = last_q;
		next_ctl_oe   = ctl_oe;
		next_nib_oe   = nib_oe;
		next_wr_ready = wr_ready;
		next_rd_valid = 1'b0;
		case (state)
		S_IDLE: if (op_start) begin
			next_state  = S_SETUP;
			next_cnt    = 16'(SETUP_CYC - 1);
			next_op     = op_kind;
			next_base   = base_sel;
			next_byte   = instr_byte;
			next_left   = read_len;
			next_first  = 1'b1;
			next_low    = 1'b0;
			next_last   = 1'b0;
			next_lines  = '{e: 1'b0, rw: 1'b0, rs: 1'b0, nib: instr_byte[7:4]};
			next_ctl_oe = 1'b1;
			next_nib_oe = 1'b1;
		end
		S_FETCH: if (wr_valid && wr_ready) begin
			next_wr_ready = 1'b0;
			next_byte     = wr_data;
			next_last     = wr_last;
			next_first    = 1'b0;
			next_low      = 1'b0;
			next_lines    = '{e: 1'b0, rw: 1'b0, rs: 1'b1, nib: wr_data[7:4]};
			next_state    = S_SETUP;
			next_cnt      = 16'(SETUP_CYC - 1);
		end
		S_SETUP: if (cnt_zero) begin
			next_state   = S_EHI;
			next_cnt     = 16'(EHI_CYC - 1);
			next_lines.e = 1'b1;
		end
		S_EHI: if (cnt_zero) begin
			next_state   = S_HOLD;
			next_cnt     = 16'(HOLD_CYC - 1);
			next_lines.e = 1'b0;
			if (lines_q.rw && !low) begin
				next_rd_hi = rd_nib;
			end else if (lines_q.rw) begin
				next_rd_data  = {rd_hi, rd_nib};
				next_rd_valid = 1'b1;
			end
		end
		S_HOLD: if (cnt_zero && !low) begin
			next_low       = 1'b1;
			next_lines.nib = byte_q[3:0];
			next_state     = S_SETUP;
			next_cnt       = 16'(SETUP_CYC - 1);
		end else if (cnt_zero) begin
			next_state = S_GAP;
			next_cnt   = gap_load;
		end
		S_GAP: if (cnt_zero) begin
			if (op_q == OP_WRITE && (first || !last_q)) begin
				next_state    = S_FETCH;
				next_wr_ready = 1'b1;
			end else if (op_q == OP_READ && left != 8'h00) begin
				next_left   = 8'(left - 8'h01);
				next_first  = 1'b0;
				next_low    = 1'b0;
				next_nib_oe = 1'b0;
				next_lines  = '{e: 1'b0, rw: 1'b1, rs: 1'b1, nib: 4'h0};
				next_state  = S_SETUP;
				next_cnt    = 16'(SETUP_CYC - 1);
			end else begin
				next_state = S_IDLE;
				if (op_q == OP_READ) begin
					next_nib_oe = 1'b0;
				end
			end
		end
		default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state    <= S_IDLE;
			op_q     <= OP_INSTR;
			lines_q  <= '0;
			cnt      <= 16'h0000;
			base_q   <= 2'h0;
			byte_q   <= 8'h00;
			left     <= 8'h00;
			rd_hi    <= 4'h0;
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
			{first, low, last_q, ctl_oe, nib_oe, wr_ready, busy} <= 7'h00;
			pin_out  <= 16'h0000;
			pin_oe   <= 16'h0000;
		end else begin
			state    <= next_state;
			op_q     <= next_op;
			lines_q  <= next_lines;
			cnt      <= next_cnt;
			base_q   <= next_base;
			byte_q   <= next_byte;
			left     <= next_left;
			rd_hi    <= next_rd_hi;
			rd_data  <= next_rd_data;
			rd_valid <= next_rd_valid;
			{first, low, last_q, ctl_oe, nib_oe} <=
				{next_first, next_low, next_last, next_ctl_oe, next_nib_oe};
			wr_ready <= next_wr_ready;
			busy     <= (next_state != S_IDLE);
			pin_out  <= next_pin_out;
			pin_oe   <= next_pin_oe;
		end
	end

	// ****************************************
	// text to number
	// ****************************************
	clnp_num_parse u_parse (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.start    (conv_start),
		.fmt      (fmt),
		.in_valid (rd_valid),
		.in_char  (rd_data),
		.value    (conv_value),
		.done     (conv_done)
	);

	// ****************************************
	// checks
	// ****************************************
	sequence strobe_edge;
		$rose(lines_q.e) || $fell(lines_q.e);
	endsequence
	write_oe_all_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		busy && $past(busy) && op_q == OP_WRITE |-> $countones(pin_oe) == 7)
		else $error("write left a pin undriven");
	low_group_map_a: assert property (
		@(posedge sys_clk) disable iff (reset) busy && !base_q[1] |=>
		pin_out[{3'b000, base_q[0]}] == $past(lines_q.e) && pin_out[PIN_RW_OFS] == $past(lines_q.rw)
		&& pin_out[PIN_RS_OFS] == $past(lines_q.rs) && pin_out[7:4] == $past(lines_q.nib))
		else $error("low group pins misplaced");
	high_group_map_a: assert property (
		@(posedge sys_clk) disable iff (reset) busy && base_q[1] |=>
		pin_out[{3'b100, base_q[0]}] == $past(lines_q.e) && pin_out[10] == $past(lines_q.rw)
		&& pin_out[11] == $past(lines_q.rs) && pin_out[15:12] == $past(lines_q.nib))
		else $error("high group pins misplaced");
	instr_first_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		$rose(lines_q.e) && first |-> !lines_q.rs && !lines_q.rw)
		else $error("first byte not sent as instruction");
	stable_select_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		strobe_edge |-> $stable(lines_q.rs) && $stable(lines_q.rw) && $stable(lines_q.nib))
		else $error("select lines moved at strobe edge");
	high_nib_first_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		$rose(lines_q.e) && !lines_q.rw |-> lines_q.nib == (low ? byte_q[3:0] : byte_q[7:4]))
		else $error("nibble order wrong");
	read_end_input_a: assert property (
		@(posedge sys_clk) disable iff (reset)
		$fell(busy) && op_q == OP_READ |=> 4'(pin_oe >> nib_pos) == 4'h0)
		else $error("data pins still driven after read");
endmodule // clnp_port
`default_nettype wire

/* verif/clnp_lcd_model.sv */
`timescale 1ns/1ps
`default_nettype none
module clnp_lcd_model
	import clnp_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// pin group choice and pins
	input  wire logic [1:0]  base_sel,
	input  wire logic [15:0] pin_out,
	input  wire logic [15:0] pin_oe,
	output logic [15:0]      lcd_lvl
);
	// ****************************************
	// display state
	// ****************************************
	logic [7:0]  text_mem [0:31];
	logic [7:0]  glyph_mem [0:7];
	logic [8:0]  log_q [$];
	logic [15:0] oe_seen;
	logic [15:0] float_lvl;
	logic [3:0]  hi_nib;
	logic [6:0]  addr;
	logic [7:0]  b;
	logic        half;
	logic        glyph_sel;
	logic        ready;
	logic        e_d;
	wire  [3:0]  grp    = base_sel[1] ? 4'h8 : 4'h0;
	wire         e      = pin_out[grp + {3'h0, base_sel[0]}] & pin_oe[grp + {3'h0, base_sel[0]}];
	wire         rw     = pin_out[grp + 4'h2];
	wire         rs     = pin_out[grp + 4'h3];
	wire  [3:0]  nib    = pin_out[grp + 4'h4 +: 4];
	wire  [7:0]  rd_b   = text_mem[addr[4:0]];
	wire  [3:0]  rd_nib = half ? rd_b[3:0] : rd_b[7:4];
	// released lines float to a changing pattern, never the last value
	always_comb begin
		lcd_lvl = float_lvl;
		if (rw && e) begin
			lcd_lvl[grp + 4'h4 +: 4] = rd_nib;
		end
	end
	// ****************************************
	// nibble capture on strobe fall
	// ****************************************
	always @(posedge sys_clk) begin
		float_lvl <= {float_lvl[14:0], ~float_lvl[15]};
		e_d <= e;
		if (reset) begin
			float_lvl <= 16'h0000;
			half <= 1'b0;
			addr <= 7'h00;
			ready <= 1'b0;
			glyph_sel <= 1'b0;
		end else if (e_d && !e) begin
			half <= ~half;
			b = {hi_nib, nib};
			if (rw) begin
				if (half) addr <= addr + 7'h01;
			end else if (!half) begin
				hi_nib <= nib;
			end else begin
				oe_seen <= pin_oe;
				log_q.push_back({rs, b});
				if (!rs) begin
					if (b == 8'h28) ready <= 1'b1;
					if (b == 8'h01) begin
						for (int i = 0; i < 32; i++) text_mem[i] <= 8'h20;
					end
					if (b == 8'h01 || b == 8'h02) addr <= 7'h00;
					if (b[7]) begin
						addr <= b[6:0];
						glyph_sel <= 1'b0;
					end else if (b[6]) begin
						addr <= {1'b0, b[5:0]};
						glyph_sel <= 1'b1;
					end
				end else if (ready) begin
					if (glyph_sel) glyph_mem[addr[2:0]] <= b;
					else text_mem[addr[4:0]] <= b;
					addr <= addr + 7'h01;
				end
			end
		end
	end
endmodule // clnp_lcd_model
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
	$display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb
	import clnp_pkg::*;
;
	logic        sys_clk, reset, op_start, wr_valid, wr_last, busy, wr_ready;
	logic        rd_valid, conv_done;
	clnp_op_t    op_kind;
	clnp_fmt_t   fmt;
	logic [1:0]  base_sel;
	logic [7:0]  instr_byte, read_len, wr_data, rd_data;
	logic [15:0] conv_value, pin_in, pin_out, pin_oe, lcd_lvl;
	logic [7:0]  rq [$];
	int          errors, check_count;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & lcd_lvl);
	clnp_port #(.LONG_WAIT_CYC(4), .EXEC_WAIT_CYC(2)) u_dut (.sys_clk(sys_clk), .reset(reset),
		.op_start(op_start), .op_kind(op_kind), .base_sel(base_sel), .instr_byte(instr_byte),
		.read_len(read_len), .busy(busy), .wr_valid(wr_valid), .wr_data(wr_data),
		.wr_last(wr_last), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
		.fmt(fmt), .conv_value(conv_value), .conv_done(conv_done), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe));
	clnp_lcd_model u_lcd (.sys_clk(sys_clk), .reset(reset), .base_sel(base_sel),
		.pin_out(pin_out), .pin_oe(pin_oe), .lcd_lvl(lcd_lvl));
	// ****************************************
	// operation driver
	// ****************************************
	task automatic run_op(input clnp_op_t k, input logic [7:0] ins, input string s,
		input logic [7:0] rlen);
		int  idx;
		int  t;
		logic took;
		rq.delete();
		@(negedge sys_clk);
		op_kind = k;
		instr_byte = ins;
		read_len = rlen;
		op_start = 1'b1;
		idx = 0;
		wr_valid = (k == OP_WRITE);
		wr_data = s[0];
		wr_last = (s.len() <= 1);
		@(negedge sys_clk);
		op_start = 1'b0;
		for (t = 0; t < 5000; t++) begin
			// ready seen now still stands at the coming rising edge
			took = wr_valid && wr_ready;
			@(negedge sys_clk);
			if (took) begin
				idx++;
				wr_valid = (idx < s.len());
				wr_data = (idx < s.len()) ? s[idx] : 8'h00;
				wr_last = (idx == s.len() - 1);
			end
			if (rd_valid === 1'b1) rq.push_back(rd_data);
			if (busy === 1'b0) break;
		end
		`CHK("busy", 1'b0, busy)
	endtask
	task automatic conv(input string s, input clnp_radix_t r, input logic sg, input logic px,
		input logic [4:0] mx, input logic [15:0] ex);
		run_op(OP_WRITE, 8'h80, s, 8'h00);
		fmt = '{r, sg, px, mx};
		run_op(OP_READ, 8'h80, "", 8'(s.len()));
		`CHK("conv_done", 1'b1, conv_done)
		`CHK("conv_value", ex, conv_value)
		`CHK("read_count", s.len(), rq.size())
		for (int i = 0; i < rq.size(); i++) `CHK("read_byte", s[i], rq[i])
		`CHK("read_start_oe", 16'h00fd, u_lcd.oe_seen)
		repeat (2) @(negedge sys_clk);
		`CHK("nibble_oe", 4'h0, pin_oe[7:4])
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ****************************************
	// clock, watchdog, tests
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (90000) @(posedge sys_clk);
		errors++;
		print_verdict();
	end
	initial begin
		logic [15:0] mask [4];
		mask = '{16'h00fd, 16'h00fe, 16'hfd00, 16'hfe00};
		errors = 0;
		check_count = 0;
		reset = 1'b1;
		op_start = 1'b0;
		op_kind = OP_INSTR;
		base_sel = 2'h0;
		instr_byte = 8'h00;
		read_len = 8'h00;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		wr_last = 1'b0;
		fmt = '{RADIX_TEN, 1'b0, 1'b0, 5'h00};
		repeat (16) @(negedge sys_clk);
		reset = 1'b0;
		`CHK("idle_oe", 16'h0000, pin_oe)
		`CHK("idle_out", 4'h0, {busy, wr_ready, rd_valid, conv_done})
		// power-up waits shortened to keep the run brief
		run_op(OP_INSTR, 8'h30, "", 8'h00);
		repeat (100) @(negedge sys_clk);
		repeat (2) run_op(OP_INSTR, 8'h30, "", 8'h00);
		run_op(OP_INSTR, 8'h20, "", 8'h00);
		run_op(OP_INSTR, 8'h28, "", 8'h00);
		run_op(OP_INSTR, 8'h0c, "", 8'h00);
		run_op(OP_INSTR, 8'h06, "", 8'h00);
		`CHK("init_len", 7, u_lcd.log_q.size())
		`CHK("wake_up", 9'h030, u_lcd.log_q[2])
		`CHK("init_last", 9'h006, u_lcd.log_q[$])
		for (int b = 0; b < 4; b++) begin
			base_sel = 2'(b);
			run_op(OP_WRITE, 8'h80, "A", 8'h00);
			`CHK("base_data", 9'h141, u_lcd.log_q[$])
			`CHK("base_instr", 9'h080, u_lcd.log_q[$-1])
			`CHK("write_oe", mask[b], u_lcd.oe_seen)
		end
		base_sel = 2'h0;
		run_op(OP_INSTR, 8'h01, "", 8'h00);
		`CHK("clear", 8'h20, u_lcd.text_mem[0])
		run_op(OP_INSTR, 8'h02, "", 8'h00);
		`CHK("home", 9'h002, u_lcd.log_q[$])
		run_op(OP_WRITE, 8'h42, "\025", 8'h00);
		`CHK("glyph", 8'h15, u_lcd.glyph_mem[2])
		conv("123x", RADIX_TEN, 0, 0, 5'h00, 16'h007b);
		conv("1234.", RADIX_TEN, 0, 0, 5'h02, 16'h000c);
		conv("-42.", RADIX_TEN, 1, 0, 5'h00, 16'hffd6);
		conv("- 7.", RADIX_TEN, 1, 0, 5'h00, 16'h0007);
		conv("aF3.", RADIX_SIXTEEN, 0, 0, 5'h00, 16'h0af3);
		conv("12$1c.", RADIX_SIXTEEN, 0, 1, 5'h00, 16'h001c);
		conv("-$1b4.", RADIX_SIXTEEN, 1, 1, 5'h00, 16'hfe4c);
		conv("$ $5f.", RADIX_SIXTEEN, 0, 1, 5'h00, 16'h005f);
		conv("10%11.", RADIX_TWO, 0, 1, 5'h00, 16'h0003);
		conv("11111111111111111.", RADIX_TWO, 0, 0, 5'h00, 16'hffff);
		conv("%101.", RADIX_ANY, 0, 0, 5'h00, 16'h0005);
		conv("$1f.", RADIX_ANY, 0, 0, 5'h00, 16'h001f);
		conv("99.", RADIX_ANY, 0, 0, 5'h00, 16'h0063);
		conv("-99999.", RADIX_ANY, 1, 0, 5'h00, 16'h8000);
		conv("40000.", RADIX_ANY, 1, 0, 5'h00, 16'h7fff);
		print_verdict();
	end
endmodule // tb
`default_nettype wire
